// File: hdl/hw_loop_pkg.sv
// package: constants and carriers for the hardware loop sequencer
package hw_loop_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NEST_W = 3;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_COUNT       = 4'h0;
    localparam logic [3:0] OFS_START       = 4'h1;
    localparam logic [3:0] OFS_END         = 4'h2;
    localparam logic [3:0] OFS_CORE_CTRL   = 4'h3;
    localparam logic [3:0] OFS_STATUS      = 4'h4;
    localparam logic [3:0] OFS_SHADOW_CNT  = 4'h5;
    localparam logic [3:0] OFS_SHADOW_STRT = 4'h6;
    localparam logic [3:0] OFS_SHADOW_END  = 4'h7;

    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int NEST_LSB   = 8;
    localparam int NEST_MSB   = 10;
    localparam int ACTIVE_BIT = 7;
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 24'hFF_FFFF;
    localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
    localparam logic [ADDR_W-1:0] PC_STEP     = 24'h00_0004;
    localparam logic [ADDR_W-1:0] WORD_STEP   = 24'h00_0002;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic                    valid;
        logic [ADDR_W-1:0]       pc;
        logic [3:0]              src_sel;
        logic signed [15:0]      signed_end_offset;
    } loop_cmd_type;

    typedef struct packed {
        logic [DATA_W-1:0] count;
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
    } loop_frame_type;

endpackage

// File: hdl/hardware_loop_register_count.sv
// module: register-count hardware loop sequencer
`timescale 1ns/10ps
module hardware_loop_register_count #(
    parameter int ADDR_W = hw_loop_pkg::ADDR_W,
    parameter int DATA_W = hw_loop_pkg::DATA_W
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    // instruction issue
    input  wire hw_loop_pkg::loop_cmd_type loop_cmd,
    input  wire logic [DATA_W*16-1:0]      working_regs,
    // fetch side
    input  wire logic                      fetch_valid,
    input  wire logic [ADDR_W-1:0]         fetch_pc,
    output logic                           redirect_valid,
    output logic [ADDR_W-1:0]              redirect_pc,
    output logic                           setup_busy,
    // status
    output logic                           loop_active_flag,
    output logic [2:0]                     loop_nest_level,
    // register port
    input  wire logic [3:0]                reg_addr,
    input  wire logic [DATA_W-1:0]         reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [ADDR_W-1:0]              reg_rdata
);

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam int                  NEST_W_C  = hw_loop_pkg::NEST_W;
    localparam int                  NEST_LSB  = hw_loop_pkg::NEST_LSB;
    localparam int                  NEST_MSB  = hw_loop_pkg::NEST_MSB;
    localparam logic [NEST_W_C-1:0] NEST_ONE  = 3'h1;
    localparam logic [NEST_W_C-1:0] NEST_ZERO = 3'h0;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {IDLE, SETUP2} setup_state_type;

    setup_state_type             setup_reg;
    logic [DATA_W-1:0]           loop_count_reg;
    logic [ADDR_W-1:0]           loop_start_addr_reg;
    logic [ADDR_W-1:0]           loop_end_addr_reg;
    hw_loop_pkg::loop_frame_type shadow_reg;
    logic [DATA_W-1:0]           core_control_reg;
    logic                        active_reg;

    // ----------------------------------------
    // address math
    // ----------------------------------------
    // first body word sits right after the two-word instruction
    function automatic logic [ADDR_W-1:0] start_addr_calc(
        input logic [ADDR_W-1:0] pc
    );
        start_addr_calc = pc + ADDR_W'(hw_loop_pkg::PC_STEP);
    endfunction

    // offset counts words, so it is doubled into a byte address
    function automatic logic [ADDR_W-1:0] end_addr_calc(
        input logic [ADDR_W-1:0]  pc,
        input logic signed [15:0] ofs
    );
        logic [ADDR_W-1:0] adv;
        logic [ADDR_W-1:0] ext;
        adv           = start_addr_calc(pc);
        ext           = ADDR_W'(signed'(ofs));
        end_addr_calc = adv + (ext << 1);
    endfunction

    // ----------------------------------------
    // nest and select
    // ----------------------------------------
    // nest level steps by one; wraps silently past seven
    function automatic logic [NEST_W_C-1:0] nest_step(
        input logic [NEST_W_C-1:0] level,
        input logic                up
    );
        if (up) begin
            nest_step = level + NEST_ONE;
        end else begin
            nest_step = level - NEST_ONE;
        end
    endfunction

    // count source is one slice of the register file
    function automatic logic [DATA_W-1:0] pick_reg(
        input logic [DATA_W*16-1:0] regs,
        input logic [3:0]           sel
    );
        pick_reg = regs[sel*DATA_W +: DATA_W];
    endfunction

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    // unused offsets read as zero
    function automatic logic [ADDR_W-1:0] read_mux(
        input logic [3:0] addr
    );
        unique case (addr)
            hw_loop_pkg::OFS_COUNT:       read_mux = ADDR_W'(loop_count_reg);
            hw_loop_pkg::OFS_START:       read_mux = loop_start_addr_reg;
            hw_loop_pkg::OFS_END:         read_mux = loop_end_addr_reg;
            hw_loop_pkg::OFS_CORE_CTRL:   read_mux = ADDR_W'(core_control_reg);
            hw_loop_pkg::OFS_STATUS:      read_mux = ADDR_W'(active_reg) << hw_loop_pkg::ACTIVE_BIT;
            hw_loop_pkg::OFS_SHADOW_CNT:  read_mux = ADDR_W'(shadow_reg.count);
            hw_loop_pkg::OFS_SHADOW_STRT: read_mux = shadow_reg.start_addr;
            hw_loop_pkg::OFS_SHADOW_END:  read_mux = shadow_reg.end_addr;
            default:                      read_mux = '0;
        endcase
    endfunction

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    logic                start_event;
    logic                at_end;
    logic                last_iter;
    logic                sw_write;
    logic [NEST_W_C-1:0] nest_now;
    logic [NEST_W_C-1:0] nest_up;
    logic [NEST_W_C-1:0] nest_down;

    assign nest_now    = core_control_reg[NEST_MSB:NEST_LSB];
    assign nest_up     = nest_step(nest_now, 1'b1);
    assign nest_down   = nest_step(nest_now, 1'b0);
    // second setup cycle refuses a new command
    assign start_event = loop_cmd.valid && (setup_reg == IDLE);
    assign at_end      = active_reg && fetch_valid && (fetch_pc == loop_end_addr_reg);
    assign last_iter   = at_end && (loop_count_reg == hw_loop_pkg::COUNT_RESET);
    // loop events win over a software write in the same cycle
    assign sw_write    = reg_write && !start_event && !at_end;

    // ----------------------------------------
    // setup sequencer
    // ----------------------------------------
    // two cycles; fetch held off during the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            setup_reg <= IDLE;
        end else begin
            unique case (setup_reg)
                IDLE: begin
                    if (loop_cmd.valid) begin
                        setup_reg <= SETUP2;
                    end
                end
                SETUP2: begin
                    setup_reg <= IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // setup busy
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            setup_busy <= 1'b0;
        end else begin
            setup_busy <= start_event;
        end
    end

    // ----------------------------------------
    // loop count
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            loop_count_reg <= hw_loop_pkg::COUNT_RESET;
        end else if (start_event) begin
            loop_count_reg <= pick_reg(working_regs, loop_cmd.src_sel);
        end else if (last_iter) begin
            loop_count_reg <= shadow_reg.count;
        end else if (at_end) begin
            loop_count_reg <= loop_count_reg - 16'h0001;
        end else if (sw_write && (reg_addr == hw_loop_pkg::OFS_COUNT)) begin
            // software save/restore for deeper nesting
            loop_count_reg <= reg_wdata;
        end
    end

    // ----------------------------------------
    // loop start address
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            loop_start_addr_reg <= hw_loop_pkg::ADDR_RESET;
        end else if (start_event) begin
            loop_start_addr_reg <= start_addr_calc(loop_cmd.pc);
        end else if (last_iter) begin
            loop_start_addr_reg <= shadow_reg.start_addr;
        end
    end

    // ----------------------------------------
    // loop end address
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            loop_end_addr_reg <= hw_loop_pkg::ADDR_RESET;
        end else if (start_event) begin
            loop_end_addr_reg <= end_addr_calc(loop_cmd.pc, loop_cmd.signed_end_offset);
        end else if (last_iter) begin
            loop_end_addr_reg <= shadow_reg.end_addr;
        end
    end

    // ----------------------------------------
    // shadows
    // ----------------------------------------
    // only one shadow level: a third level overwrites it, software must save
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shadow_reg.count      <= hw_loop_pkg::COUNT_RESET;
            shadow_reg.start_addr <= hw_loop_pkg::ADDR_RESET;
            shadow_reg.end_addr   <= hw_loop_pkg::ADDR_RESET;
        end else if (start_event) begin
            // old values are taken while the new ones load at the same edge
            shadow_reg.count      <= loop_count_reg;
            shadow_reg.start_addr <= loop_start_addr_reg;
            shadow_reg.end_addr   <= loop_end_addr_reg;
        end
    end

    // ----------------------------------------
    // nest level
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_control_reg <= hw_loop_pkg::CTRL_RESET;
        end else if (start_event) begin
            core_control_reg[NEST_MSB:NEST_LSB] <= nest_up;
        end else if (last_iter) begin
            core_control_reg[NEST_MSB:NEST_LSB] <= nest_down;
        end else if (sw_write && (reg_addr == hw_loop_pkg::OFS_CORE_CTRL)) begin
            core_control_reg <= reg_wdata;
        end
    end

    // ----------------------------------------
    // loop active
    // ----------------------------------------
    // stays set while an outer loop still runs after an inner exit
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            active_reg <= 1'b0;
        end else if (start_event) begin
            active_reg <= 1'b1;
        end else if (last_iter) begin
            active_reg <= (nest_down != NEST_ZERO);
        end
    end

    // ----------------------------------------
    // branch back
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            redirect_valid <= 1'b0;
        end else begin
            redirect_valid <= at_end && !last_iter;
        end
    end

    // ----------------------------------------
    // branch target
    // ----------------------------------------
    // registered, so the target is the start address seen now
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            redirect_pc <= hw_loop_pkg::ADDR_RESET;
        end else begin
            redirect_pc <= loop_start_addr_reg;
        end
    end

    // ----------------------------------------
    // active flag out
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            loop_active_flag <= 1'b0;
        end else begin
            loop_active_flag <= active_reg;
        end
    end

    // ----------------------------------------
    // nest level out
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            loop_nest_level <= NEST_ZERO;
        end else begin
            loop_nest_level <= nest_now;
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    // data stand one cycle only, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= read_mux(reg_addr);
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// File: bench/hw_loop_assertions.sv
// checker: port assertions for the loop sequencer
`timescale 1ns/10ps
module hw_loop_checker (
    input wire logic                      ref_clk,
    input wire logic                      reset,
    input wire hw_loop_pkg::loop_cmd_type loop_cmd,
    input wire logic                      fetch_valid,
    input wire logic                      redirect_valid,
    input wire logic                      setup_busy,
    input wire logic                      loop_active_flag,
    input wire logic [2:0]                loop_nest_level
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence start_cmd;
        loop_cmd.valid && !setup_busy;
    endsequence
    // status lags state by one, so three quiet cycles are needed
    sequence quiet;
        !fetch_valid && !loop_cmd.valid;
    endsequence
    a_busy_after_cmd: assert property (start_cmd |=> setup_busy)
        else $error("busy missing");
    a_busy_one_cycle: assert property (setup_busy |=> !setup_busy)
        else $error("busy too long");
    a_flag_on_start: assert property (start_cmd |=> ##1 loop_active_flag)
        else $error("active flag missing");
    a_level_up: assert property (start_cmd ##1 1 |=> loop_nest_level == $past(loop_nest_level) + 3'd1)
        else $error("level not raised");
    a_redirect_cause: assert property (redirect_valid |-> $past(fetch_valid))
        else $error("redirect without fetch");
    a_redirect_pulse: assert property (redirect_valid |=> !redirect_valid)
        else $error("redirect too long");
    a_exit_level: assert property ($fell(loop_active_flag) |-> loop_nest_level == 3'd0)
        else $error("level left on exit");
    a_flag_holds: assert property (quiet [*3] |-> $stable(loop_active_flag))
        else $error("active flag moved");
endmodule
bind hardware_loop_register_count hw_loop_checker hw_loop_checker_i (.ref_clk, .reset, .loop_cmd,
    .fetch_valid, .redirect_valid, .setup_busy, .loop_active_flag, .loop_nest_level);

// File: bench/hardware_loop_register_count_tb.sv
// bench: directed tests of the loop sequencer
`timescale 1ns/10ps
module hardware_loop_register_count_tb;
    logic                      ref_clk = 0;
    logic                      reset = 1;
    hw_loop_pkg::loop_cmd_type loop_cmd = '0;
    logic [255:0]              working_regs = '0;
    logic                      fetch_valid = 0;
    logic [23:0]               fetch_pc = '0;
    logic [3:0]                reg_addr = '0;
    logic [15:0]               reg_wdata = '0;
    logic                      reg_write = 0;
    logic                      reg_read = 0;
    logic                      redirect_valid, setup_busy, loop_active_flag;
    logic [23:0]               redirect_pc, reg_rdata;
    logic [2:0]                loop_nest_level;
    int                        bad_count = 0, check_count = 0, cyc = 0;
    hardware_loop_register_count hardware_loop_register_count_i (.ref_clk, .reset, .loop_cmd,
        .working_regs, .fetch_valid, .fetch_pc, .redirect_valid, .redirect_pc, .setup_busy,
        .loop_active_flag, .loop_nest_level, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // run needs about 64 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic rd(logic [3:0] a, logic [23:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge ref_clk);
        reg_read <= 0;
        #1 cmp($sformatf("reg %0d", a), exp, reg_rdata);
    endtask
    task automatic cmd(logic [23:0] pc, logic [3:0] sel, logic [15:0] ofs);
        @(posedge ref_clk);
        loop_cmd <= '{1'b1, pc, sel, ofs};
        @(posedge ref_clk);
        loop_cmd.valid <= 0;
        #1 cmp("busy", 1, setup_busy);
        @(posedge ref_clk);
        #1 cmp("active", 1, loop_active_flag);
    endtask
    task automatic fetch(logic [23:0] pc, logic rv, logic [23:0] rp);
        @(posedge ref_clk);
        fetch_valid <= 1;
        fetch_pc <= pc;
        @(posedge ref_clk);
        fetch_valid <= 0;
        #1 cmp("redirect", rv, redirect_valid);
        if (rv) cmp("target", rp, redirect_pc);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        working_regs[7*16 +: 16] = 16'h0002;
        working_regs[15*16 +: 16] = 16'hFFFF;
        repeat (3) @(posedge ref_clk);
        reset <= 0;
        rd(4'h2, 24'hFF_FFFF);
        rd(4'h3, 24'h00_0000);
        // start address is read-only; the write must not land
        @(posedge ref_clk);
        reg_addr <= 4'h1;
        reg_wdata <= 16'h1234;
        reg_write <= 1;
        @(posedge ref_clk);
        reg_write <= 0;
        rd(4'h1, 24'hFF_FFFF);
        $display("test reset done");
        cmd(24'h00_2000, 4'h7, 16'h0006);
        rd(4'h0, 24'h00_0002);
        rd(4'h1, 24'h00_2004);
        rd(4'h2, 24'h00_2010);
        rd(4'h3, 24'h00_0100);
        rd(4'h4, 24'h00_0080);
        rd(4'h5, 24'h00_0000);
        rd(4'h6, 24'hFF_FFFF);
        $display("test start done");
        cmd(24'h00_2006, 4'h3, 16'h0001);
        rd(4'h3, 24'h00_0200);
        rd(4'h5, 24'h00_0002);
        rd(4'h7, 24'h00_2010);
        fetch(24'h00_200C, 0, 0);
        rd(4'h1, 24'h00_2004);
        rd(4'h3, 24'h00_0100);
        cmp("level", 1, loop_nest_level);
        // body slots fetched here hold no flow change or table access
        $display("test nest done");
        fetch(24'h00_2006, 0, 0);
        fetch(24'h00_2010, 1, 24'h00_2004);
        fetch(24'h00_2010, 1, 24'h00_2004);
        fetch(24'h00_2010, 0, 0);
        // single shadow still holds the outer frame
        rd(4'h2, 24'h00_2010);
        rd(4'h3, 24'h00_0000);
        rd(4'h4, 24'h00_0000);
        cmp("flag", 0, loop_active_flag);
        $display("test iterate done");
        cmd(24'h00_3000, 4'hF, 16'hFFFD);
        rd(4'h0, 24'h00_FFFF);
        rd(4'h2, 24'h00_2FFE);
        $display("test backward done");
        test_done();
    end
endmodule
